// *** core/afe_cfg.svh ***
// offsets, field positions, reset values and timing counts of the status, mask and control bank
`ifndef AFE_CFG_SVH
`define AFE_CFG_SVH

`define AFE_ADDR_W 8
`define AFE_DATA_W 8

`define AFE_OFS_FLAGS 8'h01
`define AFE_OFS_REG_STATUS 8'h02
`define AFE_OFS_MASK 8'h03
`define AFE_OFS_LOOP_RX_AND_REGULATOR_CONFIG 8'h04
`define AFE_OFS_LOOP_RX_HYSTERESIS_CONFIG 8'h05
`define AFE_OFS_AMPLIFIER_ENABLES 8'h06
`define AFE_OFS_LED_AND_TX_ENABLES 8'h07
`define AFE_OFS_CONTROL 8'h08

`define AFE_RST_FLAGS 8'h00
`define AFE_RST_MASK 8'h00
`define AFE_RST_LOOP_RX_AND_REGULATOR_CONFIG 8'h20
`define AFE_RST_LOOP_RX_HYSTERESIS_CONFIG 8'h00
`define AFE_RST_AMPLIFIER_ENABLES 8'h00
`define AFE_RST_LED_AND_TX_ENABLES 8'h00
`define AFE_RST_CONTROL 8'h00

`define AFE_BIT_SUPPLY_LOW 6
`define AFE_BIT_REG_ERR 5
`define AFE_BIT_THERM_SD 4
`define AFE_BIT_THERM_WARN 3
`define AFE_BIT_LOOP_RX 0
`define AFE_BIT_POWER_GOOD 1
`define AFE_BIT_STATUS_ON_RX 0
`define AFE_BIT_DEG_HI 7
`define AFE_BIT_DEG_LO 6
`define AFE_BIT_PULLDOWN 5
`define AFE_BIT_VSEL_HI 4
`define AFE_BIT_VSEL_LO 3
`define AFE_BIT_HYST 5
`define AFE_BIT_RX_ON 5
`define AFE_BIT_PAMP_ON 3
`define AFE_BIT_PGAIN_ON 2
`define AFE_BIT_LEDREG_ON 0
`define AFE_BIT_LED_CHOICE 7
`define AFE_BIT_LED_GATE 2
`define AFE_BIT_TX_ON 1
`define AFE_BIT_REG_OFF 5
`define AFE_BIT_BROWNOUT_OFF 4
`define AFE_BIT_REGFAULT_BYP 3
`define AFE_BIT_THERM_ALLOW 2
`define AFE_BIT_SOFT_CLEAR 1

`define AFE_MUX_STATUS_CODE 3'h2

`define AFE_CLK_MHZ 40
`define AFE_DEG1_US 125
`define AFE_DEG2_US 1000
`define AFE_DEG3_US 20000
`define AFE_DEG1_CYC (`AFE_DEG1_US * `AFE_CLK_MHZ)
`define AFE_DEG2_CYC (`AFE_DEG2_US * `AFE_CLK_MHZ)
`define AFE_DEG3_CYC (`AFE_DEG3_US * `AFE_CLK_MHZ)
`define AFE_STRAP_WAIT 2'h3

`endif

// *** core/afe_pkg.sv ***
// types shared by the status, mask and control bank
package afe_pkg;

	typedef enum logic [1:0] {
		AFE_DEG_NONE = 2'h0,
		AFE_DEG_125US = 2'h1,
		AFE_DEG_1MS = 2'h2,
		AFE_DEG_20MS = 2'h3
	} afe_deg_sel_t;

	typedef struct packed {
		logic supply_low;
		logic reg_err;
		logic therm_sd;
		logic therm_warn;
		logic loop_rx;
	} afe_flags_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} afe_req_t;

endpackage

// *** core/afe_deglitch.sv ***
// selectable deglitch filter for the loop receive input
`timescale 1ns/100ps
module afe_deglitch
	import afe_pkg::*;
#(
	parameter int CNT_W = 20,
	parameter int CYC1 = 5000,
	parameter int CYC2 = 40000,
	parameter int CYC3 = 800000
)
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic sig_i,
	input wire afe_deg_sel_t sel_i,
	output logic sig_o
);

	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] limit;
	wire differs = sig_i != sig_o;
	wire expired = count >= limit - CNT_W'(1);

	always_comb
	begin
		unique case (sel_i)
			AFE_DEG_NONE: limit = CNT_W'(1);
			AFE_DEG_125US: limit = CNT_W'(CYC1);
			AFE_DEG_1MS: limit = CNT_W'(CYC2);
			AFE_DEG_20MS: limit = CNT_W'(CYC3);
		endcase
	end

	// a new level must hold for the whole window; any bounce restarts it
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			count <= '0;
			sig_o <= 1'b0;
		end
		else if (!differs)
			count <= '0;
		else if (sel_i == AFE_DEG_NONE || expired)
		begin
			count <= '0;
			sig_o <= sig_i;
		end
		else
			count <= count + CNT_W'(1);
	end

endmodule

// *** core/afe_regs.sv ***
// status, interrupt mask, enable and fault policy register bank of the detector front end
//
// Overview of operation
// - power good reads one only when regulator good and on
// - mask bits six, five suppress their interrupt
// - mask bits four, three suppress; masks reset zero
// - status bit drives host rx pin on unmasked flag
// - voltage field defaults from pin, then writable
// - config register resets to 20h, pulldown set
// - enable bit five switches loop receiver
// - enable bits three, two, zero switch amplifiers, regulator
// - led pin gated by bit two; bit seven chooses
// - second enable bit one switches loop transmitter
// - control bit five turns regulator off
// - control bit four disables brown-out monitor
// - bit three zero lets regulator error fault
// - control bit two lets over-temperature fault, flag
// - soft clear restores defaults, keeps voltage, flags
// - status flags sticky, cleared by reading
// - multipurpose pin code two shows unmasked errors
`include "afe_cfg.svh"
`timescale 1ns/100ps
module afe_regs
	import afe_pkg::*;
#(
	parameter int DEG1_CYC = `AFE_DEG1_CYC,
	parameter int DEG2_CYC = `AFE_DEG2_CYC,
	parameter int DEG3_CYC = `AFE_DEG3_CYC,
	parameter int DEG_CNT_W = 20
)
(
	input wire logic clk_i,
	input wire logic reset_i,
	// register access from the serial interface
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// pins and analog comparators
	input wire logic regulator_voltage_pin_i,
	input wire logic regulator_above_thr_i,
	input wire logic loop_rx_i,
	input wire logic led_a_enable_input_i,
	input wire logic led_b_enable_input_i,
	// events from on-chip monitors, same clock
	input wire logic supply_low_evt_i,
	input wire logic reg_err_evt_i,
	input wire logic over_temp_evt_i,
	input wire logic therm_warn_evt_i,
	input wire logic [2:0] mux_pin_mode_i,
	output logic host_rx_status_o,
	output logic host_rx_status_en_o,
	output logic mux_pin_o,
	output logic mux_pin_oe_n_o,
	output logic loop_rx_deglitched_o,
	output logic loop_rx_pulldown_sel_o,
	output logic [1:0] regulator_voltage_sel_o,
	output logic loop_rx_hysteresis_sel_o,
	output logic loop_receiver_on_o,
	output logic photo_input_amp_on_o,
	output logic photo_gain_amp_on_o,
	output logic led_regulator_on_o,
	output logic led_block_on_o,
	output logic loop_transmitter_on_o,
	output logic regulator_off_o,
	output logic brownout_monitor_off_o,
	output logic fault_mode_o
);

	////////////////////////////////////////////////////////////////////////////////
	// storage
	logic [7:0] interrupt_mask;
	logic [7:0] loop_rx_and_regulator_config;
	logic [7:0] loop_rx_hysteresis_config;
	logic [7:0] amplifier_enables;
	logic [7:0] led_and_tx_enables;
	logic [7:0] fault_policy_control;
	afe_flags_t flags;
	logic [1:0] regulator_voltage_sel;
	logic [1:0] strap_wait;
	logic [4:0] sync_a;
	logic [4:0] sync_b;
	logic rx_deglitched;

	////////////////////////////////////////////////////////////////////////////////
	// decode
	// both strobes in one cycle: the read returns the value before the write
	afe_req_t req;
	assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, wdata: reg_wdata_i};

	wire wr_mask = req.wr && req.addr == `AFE_OFS_MASK;
	wire wr_cfg1 = req.wr && req.addr == `AFE_OFS_LOOP_RX_AND_REGULATOR_CONFIG;
	wire wr_cfg2 = req.wr && req.addr == `AFE_OFS_LOOP_RX_HYSTERESIS_CONFIG;
	wire wr_en1 = req.wr && req.addr == `AFE_OFS_AMPLIFIER_ENABLES;
	wire wr_en2 = req.wr && req.addr == `AFE_OFS_LED_AND_TX_ENABLES;
	wire wr_ctrl = req.wr && req.addr == `AFE_OFS_CONTROL;
	wire rd_flags = req.rd && req.addr == `AFE_OFS_FLAGS;
	wire soft_clear = wr_ctrl && req.wdata[`AFE_BIT_SOFT_CLEAR];

	// synchronised pins: 0 voltage strap, 1 good comparator, 2 loop rx, 3 led a, 4 led b
	wire strap_pin = sync_b[0];
	wire reg_above_thr = sync_b[1];
	wire loop_rx_sync = sync_b[2];
	wire led_a_sync = sync_b[3];
	wire led_b_sync = sync_b[4];

	wire regulator_off = fault_policy_control[`AFE_BIT_REG_OFF];
	wire brownout_off = fault_policy_control[`AFE_BIT_BROWNOUT_OFF];
	wire regfault_bypass = fault_policy_control[`AFE_BIT_REGFAULT_BYP];
	wire therm_allow = fault_policy_control[`AFE_BIT_THERM_ALLOW];
	wire rx_on = amplifier_enables[`AFE_BIT_RX_ON];

	wire regulator_power_good = reg_above_thr && !regulator_off;

	////////////////////////////////////////////////////////////////////////////////
	// writable bits per register; reserved bits always read back zero
	localparam logic [7:0] WR_BITS_MASK = 8'((1 << `AFE_BIT_SUPPLY_LOW) | (1 << `AFE_BIT_REG_ERR)
		| (1 << `AFE_BIT_THERM_SD) | (1 << `AFE_BIT_THERM_WARN) | (1 << `AFE_BIT_STATUS_ON_RX));
	localparam logic [7:0] WR_BITS_CFG1 = 8'((3 << `AFE_BIT_DEG_LO) | (1 << `AFE_BIT_PULLDOWN));
	localparam logic [7:0] WR_BITS_CFG2 = 8'(1 << `AFE_BIT_HYST);
	localparam logic [7:0] WR_BITS_EN1 = 8'((1 << `AFE_BIT_RX_ON) | (1 << `AFE_BIT_PAMP_ON)
		| (1 << `AFE_BIT_PGAIN_ON) | (1 << `AFE_BIT_LEDREG_ON));
	localparam logic [7:0] WR_BITS_EN2 = 8'((1 << `AFE_BIT_LED_CHOICE) | (1 << `AFE_BIT_LED_GATE) | (1 << `AFE_BIT_TX_ON));
	// soft clear is a strobe, never stored, so it always reads zero
	localparam logic [7:0] WR_BITS_CTRL = 8'((1 << `AFE_BIT_REG_OFF) | (1 << `AFE_BIT_BROWNOUT_OFF)
		| (1 << `AFE_BIT_REGFAULT_BYP) | (1 << `AFE_BIT_THERM_ALLOW));

	////////////////////////////////////////////////////////////////////////////////
	// sticky flags
	afe_flags_t flag_set;
	afe_flags_t next_flags;
	assign flag_set = '{
		supply_low: supply_low_evt_i && !brownout_off,
		reg_err: reg_err_evt_i,
		therm_sd: over_temp_evt_i && therm_allow,
		therm_warn: therm_warn_evt_i,
		loop_rx: rx_deglitched && rx_on
	};
	// a read clears, but an event in the same cycle survives it
	assign next_flags = rd_flags ? flag_set : (flags | flag_set);

	wire [7:0] flags_word = {1'b0, flags.supply_low, flags.reg_err, flags.therm_sd, flags.therm_warn,
		2'b00, flags.loop_rx};
	wire [3:0] unmasked = flags_word[`AFE_BIT_SUPPLY_LOW:`AFE_BIT_THERM_WARN]
		& ~interrupt_mask[`AFE_BIT_SUPPLY_LOW:`AFE_BIT_THERM_WARN];
	// loop rx flag has no mask and never raises the status pins
	wire any_unmasked = |unmasked;
	wire fault_cause = (flags.reg_err && !regfault_bypass) || (flags.therm_sd && therm_allow);

	wire led_chosen = led_and_tx_enables[`AFE_BIT_LED_CHOICE] ? led_b_sync : led_a_sync;
	wire led_on = led_and_tx_enables[`AFE_BIT_LED_GATE] && led_chosen;
	wire mux_status_mode = mux_pin_mode_i == `AFE_MUX_STATUS_CODE;

	// next values of the registered pin outputs
	wire next_host_rx_status_en = interrupt_mask[`AFE_BIT_STATUS_ON_RX];
	wire next_host_rx_status = next_host_rx_status_en && any_unmasked;
	wire next_mux_pin_oe_n = !mux_status_mode;
	wire next_mux_pin = mux_status_mode && any_unmasked;
	wire next_loop_rx_deglitched = rx_deglitched && rx_on;

	////////////////////////////////////////////////////////////////////////////////
	// read data
	logic [7:0] rd_word;
	always_comb
	begin
		unique case (req.addr)
			`AFE_OFS_FLAGS: rd_word = flags_word;
			`AFE_OFS_REG_STATUS: rd_word = {6'h00, regulator_power_good, 1'b0};
			`AFE_OFS_MASK: rd_word = interrupt_mask;
			`AFE_OFS_LOOP_RX_AND_REGULATOR_CONFIG: rd_word = {loop_rx_and_regulator_config[7:5], regulator_voltage_sel, 3'h0};
			`AFE_OFS_LOOP_RX_HYSTERESIS_CONFIG: rd_word = loop_rx_hysteresis_config;
			`AFE_OFS_AMPLIFIER_ENABLES: rd_word = amplifier_enables;
			`AFE_OFS_LED_AND_TX_ENABLES: rd_word = led_and_tx_enables;
			`AFE_OFS_CONTROL: rd_word = fault_policy_control;
			default: rd_word = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	always_ff @(posedge clk_i)
	begin
		sync_a <= {led_b_enable_input_i, led_a_enable_input_i, loop_rx_i, regulator_above_thr_i,
			regulator_voltage_pin_i};
		sync_b <= sync_a;
	end

	afe_deglitch #(
		.CNT_W(DEG_CNT_W),
		.CYC1(DEG1_CYC),
		.CYC2(DEG2_CYC),
		.CYC3(DEG3_CYC)
	) u_rx_deglitch (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.sig_i(loop_rx_sync),
		.sel_i(afe_deg_sel_t'(loop_rx_and_regulator_config[`AFE_BIT_DEG_HI:`AFE_BIT_DEG_LO])),
		.sig_o(rx_deglitched)
	);

	////////////////////////////////////////////////////////////////////////////////
	// registers: soft clear restores all but voltage field and flags
	always_ff @(posedge clk_i)
	begin
		if (reset_i || soft_clear)
		begin
			interrupt_mask <= `AFE_RST_MASK;
			loop_rx_and_regulator_config <= `AFE_RST_LOOP_RX_AND_REGULATOR_CONFIG;
			loop_rx_hysteresis_config <= `AFE_RST_LOOP_RX_HYSTERESIS_CONFIG;
			amplifier_enables <= `AFE_RST_AMPLIFIER_ENABLES;
			led_and_tx_enables <= `AFE_RST_LED_AND_TX_ENABLES;
			fault_policy_control <= `AFE_RST_CONTROL;
		end
		else
		begin
			if (wr_mask)
				interrupt_mask <= req.wdata & WR_BITS_MASK;
			if (wr_cfg1)
				loop_rx_and_regulator_config <= req.wdata & WR_BITS_CFG1;
			if (wr_cfg2)
				loop_rx_hysteresis_config <= req.wdata & WR_BITS_CFG2;
			if (wr_en1)
				amplifier_enables <= req.wdata & WR_BITS_EN1;
			if (wr_en2)
				led_and_tx_enables <= req.wdata & WR_BITS_EN2;
			if (wr_ctrl)
				fault_policy_control <= req.wdata & WR_BITS_CTRL;
		end
	end

	// voltage strap is caught after reset, once the synchroniser holds the pin
	// a config write in those first cycles loses its voltage bits to the strap
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			strap_wait <= `AFE_STRAP_WAIT;
			regulator_voltage_sel <= 2'h0;
		end
		else if (strap_wait != 2'h0)
		begin
			strap_wait <= strap_wait - 2'h1;
			if (strap_wait == 2'h1)
				regulator_voltage_sel <= {1'b0, strap_pin};
		end
		else if (wr_cfg1)
			regulator_voltage_sel <= req.wdata[`AFE_BIT_VSEL_HI:`AFE_BIT_VSEL_LO];
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			flags <= '0;
		else
			flags <= next_flags;
	end

	////////////////////////////////////////////////////////////////////////////////
	// registered outputs
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			reg_rdata_o <= 8'h00;
			host_rx_status_o <= 1'b0;
			host_rx_status_en_o <= 1'b0;
			mux_pin_o <= 1'b0;
			mux_pin_oe_n_o <= 1'b1;
			led_block_on_o <= 1'b0;
			fault_mode_o <= 1'b0;
			loop_rx_deglitched_o <= 1'b0;
		end
		else
		begin
			if (req.rd)
				reg_rdata_o <= rd_word;
			host_rx_status_en_o <= next_host_rx_status_en;
			host_rx_status_o <= next_host_rx_status;
			mux_pin_oe_n_o <= next_mux_pin_oe_n;
			mux_pin_o <= next_mux_pin;
			led_block_on_o <= led_on;
			fault_mode_o <= fault_cause;
			loop_rx_deglitched_o <= next_loop_rx_deglitched;
		end
	end

	// plain register fields straight to the analog blocks
	assign loop_rx_pulldown_sel_o = loop_rx_and_regulator_config[`AFE_BIT_PULLDOWN];
	assign regulator_voltage_sel_o = regulator_voltage_sel;
	assign loop_rx_hysteresis_sel_o = loop_rx_hysteresis_config[`AFE_BIT_HYST];
	assign loop_receiver_on_o = amplifier_enables[`AFE_BIT_RX_ON];
	assign photo_input_amp_on_o = amplifier_enables[`AFE_BIT_PAMP_ON];
	assign photo_gain_amp_on_o = amplifier_enables[`AFE_BIT_PGAIN_ON];
	assign led_regulator_on_o = amplifier_enables[`AFE_BIT_LEDREG_ON];
	assign loop_transmitter_on_o = led_and_tx_enables[`AFE_BIT_TX_ON];
	assign regulator_off_o = regulator_off;
	assign brownout_monitor_off_o = brownout_off;

endmodule

// *** tb/afe_regs_checker.sv ***
// port-level assertions for the status, mask and control bank
`timescale 1ns/100ps
module afe_regs_checker
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [2:0] mux_pin_mode_i,
	input wire logic host_rx_status_o,
	input wire logic host_rx_status_en_o,
	input wire logic mux_pin_oe_n_o,
	input wire logic loop_rx_pulldown_sel_o,
	input wire logic [1:0] regulator_voltage_sel_o,
	input wire logic loop_rx_hysteresis_sel_o,
	input wire logic loop_receiver_on_o,
	input wire logic photo_input_amp_on_o,
	input wire logic photo_gain_amp_on_o,
	input wire logic led_regulator_on_o,
	input wire logic loop_transmitter_on_o,
	input wire logic regulator_off_o,
	input wire logic brownout_monitor_off_o
);
default clocking cb @(posedge clk_i);
endclocking
default disable iff (reset_i);
logic [7:0] wd_q;
wire w3 = reg_wr_i && reg_addr_i == 8'h03;
wire w4 = reg_wr_i && reg_addr_i == 8'h04;
wire w5 = reg_wr_i && reg_addr_i == 8'h05;
wire w6 = reg_wr_i && reg_addr_i == 8'h06;
wire w7 = reg_wr_i && reg_addr_i == 8'h07;
wire w8 = reg_wr_i && reg_addr_i == 8'h08;
// write data kept one cycle to compare against the updated outputs
always_ff @(posedge clk_i)
	wd_q <= reg_wdata_i;
////////////////////////////////////////////////////////////////
chk_reset_defaults:
assert property ($fell(reset_i) |-> loop_rx_pulldown_sel_o && !loop_receiver_on_o)
	else $error("config defaults wrong after reset");
chk_rx_status_off:
assert property (w3 && !reg_wdata_i[0] |-> ##2 !host_rx_status_o && !host_rx_status_en_o)
	else $error("status pin still enabled");
chk_mux_idle:
assert property (mux_pin_mode_i != 3'h2 |=> mux_pin_oe_n_o)
	else $error("mux pin driven outside status mode");
chk_mux_drive:
assert property (mux_pin_mode_i == 3'h2 |=> !mux_pin_oe_n_o)
	else $error("mux pin idle in status mode");
chk_cfg_write:
assert property (w4 |=> regulator_voltage_sel_o == wd_q[4:3] && loop_rx_pulldown_sel_o == wd_q[5])
	else $error("config write not applied");
chk_loop_rx_hysteresis_config_write:
assert property (w5 |=> loop_rx_hysteresis_sel_o == wd_q[5])
	else $error("hysteresis write not applied");
chk_amplifier_enables_write:
assert property (w6 |=> {loop_receiver_on_o, photo_input_amp_on_o, photo_gain_amp_on_o, led_regulator_on_o}
	== {wd_q[5], wd_q[3:2], wd_q[0]})
	else $error("enable write not applied");
chk_led_and_tx_enables_write:
assert property (w7 |=> loop_transmitter_on_o == wd_q[1])
	else $error("transmitter enable wrong");
chk_control_write:
assert property (w8 && !reg_wdata_i[1] |=> {regulator_off_o, brownout_monitor_off_o} == wd_q[5:4])
	else $error("control write not applied");
chk_soft_clear:
assert property (w8 && reg_wdata_i[1] |=> !regulator_off_o && !loop_receiver_on_o && loop_rx_pulldown_sel_o
	&& $stable(regulator_voltage_sel_o))
	else $error("soft clear wrong");
endmodule
bind afe_regs afe_regs_checker chk (.clk_i, .reset_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .mux_pin_mode_i,
	.host_rx_status_o, .host_rx_status_en_o, .mux_pin_oe_n_o, .loop_rx_pulldown_sel_o, .regulator_voltage_sel_o,
	.loop_rx_hysteresis_sel_o,
	.loop_receiver_on_o, .photo_input_amp_on_o, .photo_gain_amp_on_o, .led_regulator_on_o, .loop_transmitter_on_o,
	.regulator_off_o, .brownout_monitor_off_o);

// *** tb/afe_host_model.sv ***
// host side of the register port: single-word writes and reads
`timescale 1ns/100ps
module afe_host_model
	import afe_pkg::*;
(
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output afe_req_t req_o
);
initial req_o = '0;
// released lines show inverted values so stale data is never mistaken
task automatic wr(input logic [7:0] a, input logic [7:0] d);
	@(posedge clk_i);
	req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
	@(posedge clk_i);
	req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
endtask
task automatic rd(input logic [7:0] a, output logic [7:0] d);
	@(posedge clk_i);
	req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
	@(posedge clk_i);
	req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
	// read data is loaded on the edge that takes the strobe and stands from the next one
	@(posedge clk_i);
	d = rdata_i;
endtask
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the status, mask and control bank
`timescale 1ns/100ps
module testbench
	import afe_pkg::*;
;
logic clk_i = 1'b0;
logic reset_i = 1'b1;
logic regulator_voltage_pin_i = 1'b1;
logic regulator_above_thr_i = 1'b1;
logic loop_rx_i = 1'b0;
logic led_a_enable_input_i = 1'b0;
logic led_b_enable_input_i = 1'b1;
logic [3:0] evt = 4'h0;
logic [2:0] mux_pin_mode_i = 3'h2;
afe_req_t req;
logic [7:0] reg_rdata_o;
logic host_rx_status_o, mux_pin_o, mux_pin_oe_n_o, loop_rx_deglitched_o, led_block_on_o, fault_mode_o;
logic regulator_off_o;
int n_fail = 0;
int samples_checked = 0;
int n;
logic [7:0] wa [6] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h02};
logic [7:0] we [6] = '{8'h79, 8'hf8, 8'h20, 8'h2d, 8'h86, 8'h02};
int lim [4] = '{1, 4, 8, 16};
logic [7:0] lw [3] = '{8'h04, 8'h84, 8'h80};
// short deglitch counts keep the run brief
afe_regs #(.DEG1_CYC(4), .DEG2_CYC(8), .DEG3_CYC(16)) dut
(
	.clk_i,
	.reset_i,
	.reg_wr_i(req.wr),
	.reg_rd_i(req.rd),
	.reg_addr_i(req.addr),
	.reg_wdata_i(req.wdata),
	.reg_rdata_o,
	.regulator_voltage_pin_i,
	.regulator_above_thr_i,
	.loop_rx_i,
	.led_a_enable_input_i,
	.led_b_enable_input_i,
	.supply_low_evt_i(evt[3]),
	.reg_err_evt_i(evt[2]),
	.over_temp_evt_i(evt[1]),
	.therm_warn_evt_i(evt[0]),
	.mux_pin_mode_i,
	.host_rx_status_o,
	.host_rx_status_en_o(),
	.mux_pin_o,
	.mux_pin_oe_n_o,
	.loop_rx_deglitched_o,
	.loop_rx_pulldown_sel_o(),
	.regulator_voltage_sel_o(),
	.loop_rx_hysteresis_sel_o(),
	.loop_receiver_on_o(),
	.photo_input_amp_on_o(),
	.photo_gain_amp_on_o(),
	.led_regulator_on_o(),
	.led_block_on_o,
	.loop_transmitter_on_o(),
	.regulator_off_o,
	.brownout_monitor_off_o(),
	.fault_mode_o
);
afe_host_model host (.clk_i, .rdata_i(reg_rdata_o), .req_o(req));
initial forever #12.5 clk_i = ~clk_i;
////////////////////////////////////////////////////////////////
task automatic tick(input int k);
	repeat (k) @(posedge clk_i);
endtask
task automatic check(input logic [7:0] got, input logic [7:0] exp);
	samples_checked++;
	if (got !== exp)
	begin
		n_fail++;
		$display("mismatch at %0t: got %h, expected %h", $time, got, exp);
	end
endtask
task automatic rchk(input logic [7:0] a, input logic [7:0] e);
	logic [7:0] d;
	host.rd(a, d);
	check(d, e);
endtask
task automatic pulse(input int i);
	evt <= 4'h1 << i;
	tick(1);
	evt <= 4'h0;
	tick(3);
endtask
task automatic print_verdict();
	$display("checks %0d, mismatches %0d", samples_checked, n_fail);
	if (n_fail == 0 && samples_checked > 0)
		$display("Test passed");
	else
		$display("Test failed");
	$finish;
endtask
////////////////////////////////////////////////////////////////
initial
begin
	repeat (2) @(posedge clk_i);
	reset_i <= 1'b0;
	tick(6);
	rchk(8'h02, 8'h02);
	rchk(8'h03, 8'h00);
	rchk(8'h04, 8'h28);
	for (int i = 5; i < 10; i++)
		rchk(i[7:0], 8'h00);
	for (int i = 0; i < 6; i++)
	begin
		host.wr(wa[i], 8'hff);
		rchk(wa[i], we[i]);
	end
	host.wr(8'h08, 8'hfd);
	rchk(8'h08, 8'h3c);
	check(8'(regulator_off_o), 8'h01);
	rchk(8'h02, 8'h00);
	host.wr(8'h08, 8'h02);
	rchk(8'h08, 8'h00);
	rchk(8'h04, 8'h38);
	rchk(8'h03, 8'h00);
	regulator_above_thr_i <= 1'b0;
	tick(4);
	rchk(8'h02, 8'h00);
	regulator_above_thr_i <= 1'b1;
	host.wr(8'h06, 8'h20);
	for (int c = 0; c < 4; c++)
	begin
		host.wr(8'h04, {c[1:0], 6'h20});
		loop_rx_i <= 1'b1;
		n = 0;
		while (loop_rx_deglitched_o !== 1'b1 && n < 40)
		begin
			tick(1);
			n++;
		end
		check(8'(n > lim[c] && n <= lim[c] + 5), 8'h01);
		rchk(8'h01, 8'h01);
		loop_rx_i <= 1'b0;
		tick(40);
	end
	rchk(8'h01, 8'h01);
	rchk(8'h01, 8'h00);
	host.wr(8'h08, 8'h04);
	for (int i = 0; i < 4; i++)
	begin
		host.wr(8'h03, 8'h01);
		pulse(i);
		check(8'({host_rx_status_o, mux_pin_o, mux_pin_oe_n_o, fault_mode_o}), 8'h0c | 8'(i == 1 || i == 2));
		rchk(8'h01, 8'h08 << i);
		tick(2);
		check(8'(host_rx_status_o), 8'h00);
		host.wr(8'h03, 8'h01 | (8'h08 << i));
		pulse(i);
		check(8'({host_rx_status_o, mux_pin_o}), 8'h00);
		rchk(8'h01, 8'h08 << i);
	end
	// regulator error bypassed and thermal fault not allowed
	host.wr(8'h08, 8'h08);
	pulse(2);
	pulse(1);
	check(8'(fault_mode_o), 8'h00);
	rchk(8'h01, 8'h20);
	for (int i = 0; i < 3; i++)
	begin
		host.wr(8'h07, lw[i]);
		tick(3);
		check(8'(led_block_on_o), 8'(i == 1));
	end
	host.wr(8'h03, 8'h00);
	pulse(0);
	check(8'(host_rx_status_o), 8'h00);
	mux_pin_mode_i <= 3'h0;
	tick(2);
	check(8'({mux_pin_o, mux_pin_oe_n_o}), 8'h01);
	print_verdict();
end
initial
begin
	#500000;
	n_fail++;
	print_verdict();
end
endmodule
